// File: shared/cfr_pkg.sv
package cfr_pkg;
	// Register groups, selected by address bits 8:5; the low five bits pick the FIFO.
	localparam int CFR_ADDR_W = 9;
	localparam logic [3:0] CFR_GRP_GLOBAL = 4'h0;
	localparam logic [3:0] CFR_GRP_CFG = 4'h1;
	localparam logic [3:0] CFR_GRP_BASE = 4'h2;
	localparam logic [3:0] CFR_GRP_USER_ADDR = 4'h3;
	localparam logic [3:0] CFR_GRP_MSG_INDEX = 4'h4;
	localparam logic [3:0] CFR_GRP_FILTER_ID = 4'h5;
	// Word indices inside the global group.
	localparam logic [4:0] CFR_IDX_CTRL = 5'h00;
	localparam logic [4:0] CFR_IDX_FILTER_ON = 5'h01;
	localparam logic [4:0] CFR_IDX_SW_ADVANCE = 5'h02;
	// Field positions.
	localparam int CFR_CTRL_CONFIG_BIT = 0;
	localparam int CFR_CFG_TX_BIT = 0;
	localparam int CFR_CFG_LAST_LSB = 8;
	localparam int CFR_INDEX_W = 5;
	localparam logic [31:0] CFR_ALIGN_MASK = 32'hffff_fffc;
	// Reset values.
	localparam logic CFR_CONFIG_RST = 1'b1;
	localparam logic [4:0] CFR_LAST_RST = 5'h1f;
	localparam logic [31:0] CFR_ZERO = 32'h0000_0000;
	// Bus answer states.
	typedef enum logic [0:0]
	{
		CFR_BUS_WAIT = 1'b0,
		CFR_BUS_DONE = 1'b1
	} cfr_bus_e;
endpackage

// File: rtl/cfr_fifo_readback.sv
// Overview of operation
// - Each of 32 FIFOs has a read-only 32-bit user address set by hardware.
// - Transmit FIFO user address returns the head, where software writes next message.
// - Receive FIFO user address returns the tail, the next message for software.
// - User address bits 1 and 0 always read zero.
// - Each FIFO has a read-only 5-bit message index; bits 31 to 5 read zero.
// - Transmit FIFO message index names the slot to be transmitted next.
// - Receive FIFO message index names the slot for the next accepted message.
// - Filter identifier writes take effect only while that filter is disabled.
module cfr_fifo_readback #(
	parameter int NUM_FIFOS = 32,
	parameter logic [31:0] MSG_BYTES = 32'h0000_0010
)(
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Avalon-MM slave.
	input wire logic [cfr_pkg::CFR_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Message engine side.
	input wire logic can_advance,
	input wire logic [4:0] can_fifo,
	// Controller state for the message engine.
	output logic config_mode,
	output logic [31:0] acceptance_filter_on
);
	import cfr_pkg::*;

	logic [1:0] rst_sync_r;
	logic rst_n;
	cfr_bus_e bus_r;
	logic [31:0] readdata_r;
	logic wait_r;
	logic config_r;
	logic [31:0] filter_on_r;
	logic [31:0] filter_id_r [NUM_FIFOS];
	logic tx_sel_r [NUM_FIFOS];
	logic [4:0] last_r [NUM_FIFOS];
	logic [31:0] base_r [NUM_FIFOS];
	logic [4:0] user_idx_r [NUM_FIFOS];
	logic [4:0] can_idx_r [NUM_FIFOS];

	// Next slot with wrap after the last slot of the FIFO.
	function automatic logic [4:0] next_slot(input logic [4:0] cur, input logic [4:0] last);
		next_slot = (cur == last) ? 5'h00 : cur + 5'h01;
	endfunction

	// Byte address of a slot; messages are word aligned whatever base is written.
	function automatic logic [31:0] slot_addr(input logic [31:0] base, input logic [4:0] slot);
		logic [31:0] off;
		off = MSG_BYTES * {27'h0000000, slot};
		slot_addr = (base + off) & CFR_ALIGN_MASK;
	endfunction

	// The reset is released through two flops so that its removal is clean.
	// Only the second flop is read, so every register leaves reset on the same edge.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// Address decode.
	wire [3:0] grp = avs_address[8:5];
	wire [4:0] sel = avs_address[4:0];
	wire req = avs_read | avs_write;
	wire wr_take = avs_write & (bus_r == CFR_BUS_DONE);
	wire sel_ok = 32'(sel) < NUM_FIFOS;
	wire wr_ctrl = wr_take & (grp == CFR_GRP_GLOBAL) & (sel == CFR_IDX_CTRL);
	wire wr_fon = wr_take & (grp == CFR_GRP_GLOBAL) & (sel == CFR_IDX_FILTER_ON);
	wire wr_adv = wr_take & (grp == CFR_GRP_GLOBAL) & (sel == CFR_IDX_SW_ADVANCE);
	wire wr_cfg = wr_take & (grp == CFR_GRP_CFG) & sel_ok & config_r;
	wire wr_base = wr_take & (grp == CFR_GRP_BASE) & sel_ok & config_r;
	wire wr_fid = wr_take & (grp == CFR_GRP_FILTER_ID) & sel_ok & !filter_on_r[sel];
	wire [4:0] adv_sel = avs_writedata[4:0];
	wire adv_ok = 32'(adv_sel) < NUM_FIFOS;
	wire can_ok = 32'(can_fifo) < NUM_FIFOS;

	// Per-FIFO readback values.
	// In configuration mode every pointer is held at slot zero, so the user address reads
	// back the base; software must not rely on it until configuration mode is left.
	wire [4:0] sel_c = sel_ok ? sel : 5'h00;
	wire [31:0] user_addr_val = slot_addr(base_r[sel_c], user_idx_r[sel_c]);
	wire [31:0] msg_index_val = {27'h0000000, can_idx_r[sel_c]};
	wire [31:0] cfg_val = {19'h00000, last_r[sel_c], 7'h00, tx_sel_r[sel_c]};

	// Unmapped addresses read as zero and ignore writes.
	logic [31:0] rd_val;
	always_comb
	begin
		rd_val = CFR_ZERO;
		case (grp)
			CFR_GRP_GLOBAL:
			begin
				if (sel == CFR_IDX_CTRL)
					rd_val = {31'h00000000, config_r};
				else if (sel == CFR_IDX_FILTER_ON)
					rd_val = filter_on_r;
			end
			CFR_GRP_CFG:
				rd_val = sel_ok ? cfg_val : CFR_ZERO;
			CFR_GRP_BASE:
				rd_val = sel_ok ? base_r[sel_c] : CFR_ZERO;
			CFR_GRP_USER_ADDR:
				rd_val = sel_ok ? user_addr_val : CFR_ZERO;
			CFR_GRP_MSG_INDEX:
				rd_val = sel_ok ? msg_index_val : CFR_ZERO;
			CFR_GRP_FILTER_ID:
				rd_val = sel_ok ? filter_id_r[sel_c] : CFR_ZERO;
			default:
				rd_val = CFR_ZERO;
		endcase
	end

	// One wait cycle per access: waitrequest drops the cycle after the request is seen.
	// Waitrequest has a flop of its own so that the pin carries no decode glitch.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus_r <= CFR_BUS_WAIT;
			wait_r <= 1'b1;
			readdata_r <= CFR_ZERO;
		end
		else
		begin
			case (bus_r)
				CFR_BUS_WAIT:
				begin
					if (req)
					begin
						bus_r <= CFR_BUS_DONE;
						wait_r <= 1'b0;
					end
					if (avs_read)
						readdata_r <= rd_val;
				end
				CFR_BUS_DONE:
				begin
					bus_r <= CFR_BUS_WAIT;
					wait_r <= 1'b1;
				end
				default:
				begin
					bus_r <= CFR_BUS_WAIT;
					wait_r <= 1'b1;
				end
			endcase
		end
	end

	// Global control.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			config_r <= CFR_CONFIG_RST;
			filter_on_r <= CFR_ZERO;
		end
		else
		begin
			if (wr_ctrl)
				config_r <= avs_writedata[CFR_CTRL_CONFIG_BIT];
			if (wr_fon)
				filter_on_r <= avs_writedata;
		end
	end

	// Per-FIFO storage. Configuration mode holds every pointer at the first slot, so
	// layout changes made there never leave a pointer beyond the new last slot.
	for (genvar i = 0; i < NUM_FIFOS; i++)
	begin : g_fifo
		wire hit = sel == 5'(i);
		wire sw_step = wr_adv & adv_ok & (adv_sel == 5'(i)) & !config_r;
		wire can_step = can_advance & can_ok & (can_fifo == 5'(i)) & !config_r;
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				tx_sel_r[i] <= 1'b0;
				last_r[i] <= CFR_LAST_RST;
				base_r[i] <= CFR_ZERO;
				filter_id_r[i] <= CFR_ZERO;
				user_idx_r[i] <= 5'h00;
				can_idx_r[i] <= 5'h00;
			end
			else
			begin
				if (wr_cfg && hit)
				begin
					tx_sel_r[i] <= avs_writedata[CFR_CFG_TX_BIT];
					last_r[i] <= avs_writedata[CFR_CFG_LAST_LSB +: CFR_INDEX_W];
				end
				if (wr_base && hit)
					base_r[i] <= avs_writedata & CFR_ALIGN_MASK;
				if (wr_fid && hit)
					filter_id_r[i] <= avs_writedata;
				if (config_r)
					user_idx_r[i] <= 5'h00;
				else if (sw_step)
					user_idx_r[i] <= next_slot(user_idx_r[i], last_r[i]);
				if (config_r)
					can_idx_r[i] <= 5'h00;
				else if (can_step)
					can_idx_r[i] <= next_slot(can_idx_r[i], last_r[i]);
			end
		end
	end

	assign avs_readdata = readdata_r;
	assign avs_waitrequest = wait_r;
	assign config_mode = config_r;
	assign acceptance_filter_on = filter_on_r;
endmodule

// File: tb/cfr_monitor.sv
module cfr_monitor (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [8:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic can_advance,
	input wire logic [4:0] can_fifo,
	input wire logic config_mode,
	input wire logic [31:0] acceptance_filter_on
);
	timeunit 1ns;
	timeprecision 1ns;
	wire rq = avs_read || avs_write;
	wire ack_rd = avs_read && !avs_waitrequest;
	wire ack_wr = avs_write && !avs_waitrequest;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	chk_wait_answer: assert property (rq && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer one cycle after request");
	chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	chk_wait_idle: assert property (!rq |=> avs_waitrequest)
		else $error("answer without request");
	chk_read_cause: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
		else $error("read data moved without read");
	chk_ua_align: assert property (ack_rd && avs_address[8:5] == 4'h3 |-> avs_readdata[1:0] == 2'h0)
		else $error("user address not aligned");
	chk_idx_upper: assert property (ack_rd && avs_address[8:5] == 4'h4 |-> avs_readdata[31:5] == 27'h0)
		else $error("index upper bits set");
	chk_filt_cause: assert property ($changed(acceptance_filter_on) |-> $past(ack_wr && avs_address == 9'h001))
		else $error("filter enables moved without write");
	chk_cfg_cause: assert property ($changed(config_mode) |-> $past(ack_wr && avs_address == 9'h000))
		else $error("config mode moved without write");
	cover property (can_advance && !config_mode);
	cover property (ack_rd && avs_address[8:5] == 4'h3);
	cover property ($fell(config_mode));
endmodule
bind cfr_fifo_readback cfr_monitor i_cfr_monitor (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .can_advance(can_advance), .can_fifo(can_fifo),
	.config_mode(config_mode), .acceptance_filter_on(acceptance_filter_on));

// File: tb/cfr_engine.sv
module cfr_engine (
	input wire logic clk,
	output logic can_advance,
	output logic [4:0] can_fifo
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		can_advance = 1'b0;
		can_fifo = 5'h00;
	end
	// A released FIFO number is inverted so a stale value differs from the number just sent.
	task automatic send(input logic [4:0] k);
		@(posedge clk);
		can_advance <= 1'b1;
		can_fifo <= k;
		@(posedge clk);
		can_advance <= 1'b0;
		can_fifo <= ~k;
	endtask
endmodule

// File: tb/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cfr_pkg::*;
	localparam logic [31:0] MB = 32'h0000_0010;
	logic clk, arst_n, avs_read, avs_write, avs_waitrequest, config_mode, can_advance;
	logic [8:0] avs_address;
	logic [4:0] can_fifo;
	logic [31:0] avs_writedata, avs_readdata, acceptance_filter_on, rd;
	int fail_count, compares;
	cfr_fifo_readback #(.MSG_BYTES(MB)) i_cfr_fifo_readback (.clk(clk), .arst_n(arst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .can_advance(can_advance),
		.can_fifo(can_fifo), .config_mode(config_mode), .acceptance_filter_on(acceptance_filter_on));
	cfr_engine i_cfr_engine (.clk(clk), .can_advance(can_advance), .can_fifo(can_fifo));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			fail_count++;
			$display("[ERR] %0t %h %h", $time, s, e);
		end
	endtask
	task give_verdict;
		if (fail_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// One idle edge after each access keeps the strobes from being driven twice in one step.
	task acc(input logic w, input logic [8:0] a, input logic [31:0] d);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge clk);
		while (avs_waitrequest)
			@(posedge clk);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask
	task rdc(input logic [8:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task s_reset;
		rdc(9'h020, 32'h0000_1f00);
		chk({31'h0, config_mode}, 32'h1);
		rdc(9'h1ff, 32'h0);
	endtask
	task s_setup;
		acc(1'b1, 9'h020, 32'h0000_0201);
		acc(1'b1, 9'h040, 32'h0000_1006);
		acc(1'b1, 9'h021, 32'h0000_0100);
		acc(1'b1, 9'h041, 32'h0000_2000);
		acc(1'b1, 9'h000, 32'h0);
		chk({31'h0, config_mode}, 32'h0);
		acc(1'b1, 9'h060, 32'hffff_ffff);
		rdc(9'h060, 32'h0000_1004);
	endtask
	task s_ring(input logic [4:0] f, input logic [31:0] b, input int n);
		for (int i = 1; i <= n + 1; i++)
		begin
			acc(1'b1, 9'h002, {27'h0, f});
			i_cfr_engine.send(f);
			rdc({4'h3, f}, b + 32'(i % n) * MB);
			rdc({4'h4, f}, 32'(i % n));
		end
	endtask
	task s_filter;
		acc(1'b1, 9'h0a0, 32'h5);
		acc(1'b1, 9'h001, 32'h1);
		chk(acceptance_filter_on, 32'h1);
		acc(1'b1, 9'h0a0, 32'h9);
		rdc(9'h0a0, 32'h5);
		acc(1'b1, 9'h001, 32'h0);
		chk(acceptance_filter_on, 32'h0);
		acc(1'b1, 9'h0a0, 32'h9);
		rdc(9'h0a0, 32'h9);
	endtask
	initial
	begin
		{arst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
		fail_count = 0;
		compares = 0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		s_reset;
		s_setup;
		s_ring(5'h00, 32'h0000_1004, 3);
		s_ring(5'h01, 32'h0000_2000, 2);
		s_filter;
		give_verdict;
	end
	initial
	begin
		#400000;
		fail_count++;
		give_verdict;
	end
endmodule
